// *** core/capture_timer_defs.svh ***
// Register offsets, field positions, reset values and channel count of the capture timer.
// Behaviour
// - 16-bit auto-reload counter, prescaled timer clock
// - Wide mode widens counter, period, captures to 32
// - Wide mode set by control register bit
// - Count up, down or alternating up/down
// - Update, trigger, capture interrupts individually enabled
// - External input can clock the counter
// - Capture counter on input edges, raise interrupt
// - Separate filter clock division from prescaler
// - Period and prescaler loaded from software values
`ifndef CAPTURE_TIMER_DEFS_SVH
`define CAPTURE_TIMER_DEFS_SVH
`define OFS_CONTROL 8'h00
`define OFS_INT_ENABLE 8'h04
`define OFS_STATUS 8'h08
`define OFS_COUNTER 8'h0c
`define OFS_PRESCALER 8'h10
`define OFS_PERIOD 8'h14
`define OFS_CAPTURE0 8'h18
`define OFS_CAPTURE1 8'h1c
`define BIT_ENABLE 0
`define BIT_DIR 1
`define POS_MODE 2
`define BIT_EXT_CLOCK 4
`define BIT_EDGE_FALL 5
`define POS_CLKDIV 6
`define BIT_WIDE 8
`define BIT_IRQ_UPDATE 0
`define BIT_IRQ_TRIGGER 1
`define BIT_IRQ_CAP0 2
`define BIT_IRQ_CAP1 3
`define RST_PERIOD 32'h0000ffff
`define RST_CONTROL 32'h00000000
`define NUM_CHANNELS 2
`endif

// *** core/capture_timer_pkg.sv ***
// Types shared by the capture timer modules.
package capture_timer_pkg;
  typedef enum logic [1:0] {
    count_edge_e = 2'h0,
    count_center1_e = 2'h1,
    count_center2_e = 2'h2,
    count_center3_e = 2'h3
  } count_mode_e;
  typedef enum logic [1:0] {
    dir_up_e = 2'h1,
    dir_down_e = 2'h2
  } dir_state_e;
endpackage

// *** core/input_edge_if.sv ***
// Interface carrying filtered input edges from the filter stage to the timer core.
`timescale 1ns/1ps
`default_nettype none
interface input_edge_if;
  logic [1:0] rise;
  logic [1:0] fall;
  modport source (output rise, output fall);
  modport sink (input rise, input fall);
endinterface
`default_nettype wire

// *** core/input_edge_filter.sv ***
// Input filter and edge detector running on its own clock-division tick.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_defs.svh"
module input_edge_filter
  import capture_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [1:0] clkdiv_i,
  input wire logic [1:0] pulse_i,
  input_edge_if.source edges
);
  logic [1:0] div_count;
  logic [1:0] level;
  logic [1:0] stable;
  logic [1:0] last;
  wire sample_tick = (div_count == clkdiv_i);
  // The filter samples on a divided tick so slow glitchy inputs settle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_count <= 2'h0;
      level <= 2'h0;
      stable <= 2'h0;
      last <= 2'h0;
    end else if (enable_i) begin
      div_count <= sample_tick ? 2'h0 : div_count + 2'h1;
      last <= stable;
      if (sample_tick) begin
        level <= pulse_i;
        stable <= (level & pulse_i) | (stable & (level | pulse_i));
      end
    end
  end
  assign edges.rise = stable & ~last & {2{enable_i}};
  assign edges.fall = ~stable & last & {2{enable_i}};
  AST_DIV_TICK: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && !sample_tick |=> div_count == $past(div_count) + 2'h1)
    else $error("Filter divider did not advance.");
endmodule
`default_nettype wire

// *** core/capture_timer.sv ***
// General-purpose timer with prescaler, wide mode, count directions and input capture.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_defs.svh"
module capture_timer
  import capture_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0] pulse_i,
  input wire logic trigger_i,
  output logic irq_o
);
  logic [31:0] control;
  logic [3:0] int_enable;
  logic [3:0] status;
  logic [31:0] counter_value;
  logic [15:0] prescaler;
  logic [15:0] presc_count;
  logic [31:0] period_value;
  logic [31:0] channel_capture_value [`NUM_CHANNELS];
  dir_state_e dir;
  input_edge_if edge_bus ();

  input_edge_filter u_filter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(clk_en_i),
    .clkdiv_i(control[`POS_CLKDIV +: 2]),
    .pulse_i(pulse_i),
    .edges(edge_bus.source)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire running = control[`BIT_ENABLE];
  wire wide_count_enable = control[`BIT_WIDE];
  wire [31:0] mask = wide_count_enable ? 32'hffffffff : 32'h0000ffff;
  wire [31:0] limit = period_value & mask;
  wire [31:0] cnt = counter_value & mask;
  wire [1:0] mode = control[`POS_MODE +: 2];
  wire [1:0] sel_edge = control[`BIT_EDGE_FALL] ? edge_bus.fall : edge_bus.rise;
  // External mode counts filtered channel 0 edges instead of prescaled ticks.
  wire ext_tick = sel_edge[0];
  wire presc_done = (presc_count == prescaler);
  wire tick = running && (control[`BIT_EXT_CLOCK] ? ext_tick : presc_done);
  wire at_top = (cnt >= limit);
  wire at_zero = (cnt == 32'h0);
  wire going_up = (mode == 2'h0) ? !control[`BIT_DIR] : (dir == dir_up_e);
  wire overflow = tick && (going_up ? at_top : at_zero);
  logic [31:0] next_counter;
  // Edge mode wraps at the period; centre modes turn round at either end.
  always_comb begin
    if (!tick) begin
      next_counter = cnt;
    end else if (mode == 2'h0) begin
      if (going_up) begin
        next_counter = at_top ? 32'h0 : cnt + 32'h1;
      end else begin
        next_counter = at_zero ? limit : cnt - 32'h1;
      end
    end else begin
      if (going_up) begin
        next_counter = at_top ? cnt - 32'h1 : cnt + 32'h1;
      end else begin
        next_counter = at_zero ? cnt + 32'h1 : cnt - 32'h1;
      end
    end
  end
  wire wr_ctrl = write_i && hit(addr_i, `OFS_CONTROL);
  wire wr_status = write_i && hit(addr_i, `OFS_STATUS);
  wire [3:0] cap_ev = {sel_edge[1], sel_edge[0], trigger_i, overflow} & {4{clk_en_i}};
  // Hardware events win over a write-one-to-clear in the same cycle.
  wire [3:0] next_status = (status & ~(wr_status ? wdata_i[3:0] : 4'h0)) | cap_ev;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      control <= `RST_CONTROL;
      int_enable <= 4'h0;
      prescaler <= 16'h0;
      period_value <= `RST_PERIOD;
    end else if (clk_en_i && write_i) begin
      if (wr_ctrl) control <= wdata_i;
      if (hit(addr_i, `OFS_INT_ENABLE)) int_enable <= wdata_i[3:0];
      if (hit(addr_i, `OFS_PRESCALER)) prescaler <= wdata_i[15:0];
      if (hit(addr_i, `OFS_PERIOD)) period_value <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      counter_value <= 32'h0;
      presc_count <= 16'h0;
      dir <= dir_up_e;
      status <= 4'h0;
    end else if (clk_en_i) begin
      status <= next_status;
      presc_count <= (!running || presc_done) ? 16'h0 : presc_count + 16'h1;
      if (write_i && hit(addr_i, `OFS_COUNTER)) begin
        counter_value <= wdata_i & mask;
      end else begin
        counter_value <= next_counter;
      end
      if (mode != 2'h0 && tick) begin
        if (going_up && at_top) dir <= dir_down_e;
        if (!going_up && at_zero) dir <= dir_up_e;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_capture
      // Capture and flag share one edge so software never sees a stale value.
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          channel_capture_value[ch] <= 32'h0;
        end else if (clk_en_i && sel_edge[ch]) begin
          channel_capture_value[ch] <= cnt;
        end
      end
    end
  endgenerate

  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0;
    if (hit(addr_i, `OFS_CONTROL)) read_mux = control;
    if (hit(addr_i, `OFS_INT_ENABLE)) read_mux = {28'h0, int_enable};
    if (hit(addr_i, `OFS_STATUS)) read_mux = {28'h0, status};
    if (hit(addr_i, `OFS_COUNTER)) read_mux = cnt;
    if (hit(addr_i, `OFS_PRESCALER)) read_mux = {16'h0, prescaler};
    if (hit(addr_i, `OFS_PERIOD)) read_mux = period_value;
    if (hit(addr_i, `OFS_CAPTURE0)) read_mux = channel_capture_value[0];
    if (hit(addr_i, `OFS_CAPTURE1)) read_mux = channel_capture_value[1];
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      rdata_o <= read_i ? read_mux : 32'h0;
      irq_o <= |(next_status & int_enable);
    end
  end

  sequence cap_edge_s;
    clk_en_i && sel_edge[0];
  endsequence
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (reset_i)
    cap_edge_s |=> channel_capture_value[0] == $past(cnt) && status[2])
    else $error("Capture value or flag missing after edge.");
  AST_NARROW: assert property (@(posedge clk_i) disable iff (reset_i)
    !wide_count_enable |-> counter_value[31:16] == 16'h0 || $past(wide_count_enable))
    else $error("Counter exceeded 16 bits in narrow mode.");
  AST_PRESC: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && running && !control[`BIT_EXT_CLOCK] && !presc_done && !write_i
    |=> counter_value == $past(counter_value))
    else $error("Counter moved between prescaler ticks.");
  AST_WRAP_UP: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && overflow && mode == 2'h0 && going_up && !write_i |=> counter_value == 32'h0)
    else $error("Up counter did not wrap to zero.");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !(|(next_status & int_enable)) |=> !irq_o)
    else $error("Interrupt raised without an enabled source.");
  AST_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && write_i && hit(addr_i, `OFS_PERIOD) |=> period_value == $past(wdata_i))
    else $error("Period write not stored.");
  AST_EXT: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && running && control[`BIT_EXT_CLOCK] && !ext_tick && !write_i
    |=> $stable(counter_value))
    else $error("External clock mode counted without an edge.");
  AST_WIDE: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_ctrl && clk_en_i |=> wide_count_enable == $past(wdata_i[`BIT_WIDE]))
    else $error("Wide enable bit not taken.");
endmodule
`default_nettype wire

// *** bench/pulse_source.sv ***
// Model of the external pulse source that drives the timer input pins.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] chan_i,
  input wire logic [7:0] count_i,
  input wire logic [7:0] gap_i,
  output logic [1:0] pulse_o,
  output logic busy_o
);
  // Each pulse stays high for gap_i cycles and then low for gap_i cycles.
  // The gap must span two filter sampling ticks, or the timer filter drops the pulse.
  // That is 2 cycles at the fastest filter setting and more when the filter is divided.
  initial begin
    pulse_o = 2'h0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (count_i) begin
          pulse_o <= chan_i;
          repeat (gap_i) @(posedge clk_i);
          pulse_o <= 2'h0;
          repeat (gap_i) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking testbench of the capture timer, with the pulse source as its far side.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic [31:0] rdata_o;
  logic [1:0] pulse_i;
  logic trigger_i = 1'b0;
  logic irq_o;
  logic go = 1'b0;
  logic [1:0] chan = 2'h1;
  logic [7:0] count = 8'h01;
  logic [7:0] gap = 8'h04;
  logic busy;
  logic [31:0] v;
  logic [31:0] w;
  int n_errors = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  capture_timer u_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .pulse_i(pulse_i), .trigger_i(trigger_i), .irq_o(irq_o));
  pulse_source u_src (.clk_i(clk_i), .go_i(go), .chan_i(chan), .count_i(count), .gap_i(gap),
    .pulse_o(pulse_i), .busy_o(busy));
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic wait_status(input int b);
    for (int i = 0; i < 200; i++) begin
      rd(`OFS_STATUS);
      if (v[b] === 1'b1) return;
    end
    n_errors++;
    stop_test();
  endtask
  task automatic wait_sig(input int which, input logic l);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      #1;
      if ((which == 0 ? irq_o : busy) === l) return;
    end
    n_errors++;
    stop_test();
  endtask
  task automatic send(input logic [1:0] c, input logic [7:0] n, input logic [7:0] g);
    @(posedge clk_i);
    chan <= c;
    count <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic t_reset_width();
    rd(`OFS_PERIOD);
    `CHK(v, 32'h0000ffff)
    rd(8'h40);
    `CHK(v, 32'h00000000)
    wr(`OFS_COUNTER, 32'h12345678);
    rd(`OFS_COUNTER);
    `CHK(v, 32'h00005678)
    wr(`OFS_CONTROL, 32'h00000100);
    wr(`OFS_COUNTER, 32'h12345678);
    wr(`OFS_PERIOD, 32'h89abcdef);
    rd(`OFS_COUNTER);
    `CHK(v, 32'h12345678)
    rd(`OFS_PERIOD);
    `CHK(v, 32'h89abcdef)
  endtask
  // About 41 running cycles at divide-by-4; the frozen stretch must add nothing.
  task automatic t_prescale();
    wr(`OFS_PERIOD, 32'h0000ffff);
    wr(`OFS_PRESCALER, 32'h00000003);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CONTROL, 32'h00000001);
    repeat (20) @(posedge clk_i);
    clk_en_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    clk_en_i <= 1'b1;
    repeat (19) @(posedge clk_i);
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_COUNTER);
    `CHK(v >= 32'h9 && v <= 32'hc, 1'b1)
    rd(`OFS_PRESCALER);
    `CHK(v, 32'h00000003)
  endtask
  task automatic t_direction();
    logic fell;
    fell = 1'b0;
    wr(`OFS_PRESCALER, 32'h0);
    wr(`OFS_COUNTER, 32'h20);
    wr(`OFS_CONTROL, 32'h00000003);
    repeat (8) @(posedge clk_i);
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_COUNTER);
    `CHK(v < 32'h20 && v > 32'h10, 1'b1)
    wr(`OFS_PERIOD, 32'h5);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CONTROL, 32'h00000005);
    w = 32'h0;
    repeat (12) begin
      rd(`OFS_COUNTER);
      `CHK(v <= 32'h5, 1'b1)
      if (v < w) fell = 1'b1;
      w = v;
    end
    `CHK(fell, 1'b1)
    wr(`OFS_CONTROL, 32'h0);
  endtask
  task automatic t_irq();
    wr(`OFS_STATUS, 32'hf);
    wr(`OFS_INT_ENABLE, 32'h1);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CONTROL, 32'h00000001);
    wait_sig(0, 1'b1);
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_STATUS);
    `CHK(v[0], 1'b1)
    wr(`OFS_INT_ENABLE, 32'h0);
    wr(`OFS_STATUS, 32'hf);
    @(posedge clk_i);
    trigger_i <= 1'b1;
    @(posedge clk_i);
    trigger_i <= 1'b0;
    rd(`OFS_STATUS);
    `CHK(v[1], 1'b1)
    `CHK(irq_o, 1'b0)
    wr(`OFS_INT_ENABLE, 32'h2);
    wait_sig(0, 1'b1);
    wr(`OFS_STATUS, 32'h2);
    wait_sig(0, 1'b0);
  endtask
  task automatic t_capture();
    wr(`OFS_STATUS, 32'hf);
    wr(`OFS_PERIOD, 32'h0000ffff);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_INT_ENABLE, 32'h4);
    wr(`OFS_CONTROL, 32'h00000001);
    send(2'h1, 8'h02, 8'h14);
    wait_status(`BIT_IRQ_CAP0);
    wait_sig(0, 1'b1);
    rd(`OFS_CAPTURE0);
    w = v;
    wr(`OFS_STATUS, 32'h4);
    wait_status(`BIT_IRQ_CAP0);
    rd(`OFS_CAPTURE0);
    `CHK(v - w >= 32'd39 && v - w <= 32'd41, 1'b1)
    wait_sig(1, 1'b0);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_INT_ENABLE, 32'h0);
  endtask
  // Channel 1 on falling edges behind a filter ticking every third cycle.
  // A capture on both edges would halve the measured spacing, so the range check catches it.
  task automatic t_channel1();
    wr(`OFS_STATUS, 32'hf);
    wr(`OFS_INT_ENABLE, 32'h8);
    wr(`OFS_CONTROL, 32'h000000a1);
    send(2'h2, 8'h02, 8'h0c);
    wait_status(`BIT_IRQ_CAP1);
    `CHK(v[2], 1'b0)
    wait_sig(0, 1'b1);
    rd(`OFS_CAPTURE1);
    w = v;
    wr(`OFS_STATUS, 32'h8);
    wait_status(`BIT_IRQ_CAP1);
    rd(`OFS_CAPTURE1);
    `CHK(v - w >= 32'd23 && v - w <= 32'd25, 1'b1)
    wait_sig(1, 1'b0);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_INT_ENABLE, 32'h0);
  endtask
  task automatic t_ext_clock();
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CONTROL, 32'h00000011);
    send(2'h1, 8'h0a, 8'h03);
    wait_sig(1, 1'b0);
    repeat (10) @(posedge clk_i);
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_COUNTER);
    `CHK(v, 32'h0000000a)
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset_width();
    t_prescale();
    t_direction();
    t_irq();
    t_capture();
    t_channel1();
    t_ext_clock();
    stop_test();
  end
endmodule
`default_nettype wire
